// *** rtl/host_parallel_register_port.sv ***
// Host parallel port onto the 32-byte interface register bank
`include "host_port_regs.svh"
`default_nettype none

// Overview of operation
// - Eight-bit two-way data bus, strobe sets direction
// - Five select lines pick one of 32 registers
// - Take part only while chip select is low
// - Drive addressed register while read and selected
// - Data drivers off outside read cycles
// - Write cycle stores bus byte into register
// - Interrupt output only when enabled in bank
module host_parallel_register_port (
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic [4:0] REGISTER_SELECT_LINES_I,
   input wire logic CHIP_SEL_N_I,
   input wire logic READ_N_I,
   input wire logic WRITE_N_I,
   input wire host_port_pkg::data_t HOST_DATA_LINES_I,
   output host_port_pkg::data_t HOST_DATA_LINES_O,
   output logic HOST_DATA_LINES_OE_O,
   output logic IRQ_O,
   input wire logic CORE_EVENT_I,
   input wire logic CORE_WR_EN_I,
   input wire host_port_pkg::reg_idx_t CORE_WR_ADDR_I,
   input wire host_port_pkg::data_t CORE_WR_DATA_I,
   input wire host_port_pkg::reg_idx_t CORE_RD_ADDR_I,
   output host_port_pkg::data_t CORE_RD_DATA_O,
   output logic HOST_WR_STB_O,
   output host_port_pkg::reg_idx_t HOST_WR_ADDR_O,
   output host_port_pkg::data_t HOST_WR_DATA_O
);
   import host_port_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [`SYNC_WIDTH-1:0] pins_s;
   logic sel;
   logic rd;
   logic wr;
   reg_idx_t rs;
   data_t dat;

   // Strobes reset to their idle (high) level so no cycle is seen early
   pin_sync #(
      .W(`SYNC_WIDTH),
      .RST_VAL(`SYNC_RST_VAL)
   ) u_pin_sync (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .d_i({CHIP_SEL_N_I, READ_N_I, WRITE_N_I,
            REGISTER_SELECT_LINES_I, HOST_DATA_LINES_I}),
      .q_o(pins_s)
   );

   assign sel = ~pins_s[`SYNC_CS_BIT];
   assign rd = sel & ~pins_s[`SYNC_RD_BIT];
   assign wr = sel & ~pins_s[`SYNC_WR_BIT];
   assign rs = pins_s[`SYNC_RS_MSB:`SYNC_RS_LSB];
   assign dat = pins_s[`SYNC_DAT_MSB:`SYNC_DAT_LSB];

   // ----------------------------------------------------------------
   // Cycle tracking
   // ----------------------------------------------------------------
   port_state_t state_q;
   port_state_t state_d;
   logic commit;
   reg_idx_t wr_addr_q;
   data_t wr_data_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         PS_IDLE: begin
            if (rd) begin
               state_d = PS_READ;
            end else if (wr) begin
               state_d = PS_WRITE;
            end
         end
         PS_READ: begin
            if (!rd) begin
               state_d = PS_IDLE;
            end
         end
         PS_WRITE: begin
            if (!wr) begin
               state_d = PS_IDLE;
            end
         end
         default: begin
            state_d = PS_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q <= PS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Commit on the trailing edge, using the last values seen in the strobe
   assign commit = (state_q == PS_WRITE) && !wr;

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wr_addr_q <= '0;
         wr_data_q <= '0;
      end else if (wr) begin
         wr_addr_q <= rs;
         wr_data_q <= dat;
      end
   end

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   data_t bank_q [`BANK_DEPTH];
   logic irq_en;
   logic irq_pend;

   assign irq_en = bank_q[`IRQ_CTRL_IDX][`IRQ_EN_BIT];
   assign irq_pend = bank_q[`IRQ_PEND_IDX][`IRQ_PEND_BIT];

   // Host write beats a core write to the same register; a core event
   // beats a host clear of the pending flag so no event is lost
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int i = 0; i < `BANK_DEPTH; i++) begin
            bank_q[i] <= `BANK_RST_VAL;
         end
      end else begin
         if (CORE_WR_EN_I) begin
            bank_q[CORE_WR_ADDR_I] <= CORE_WR_DATA_I;
         end
         if (commit) begin
            bank_q[wr_addr_q] <= wr_data_q;
         end
         if (CORE_EVENT_I) begin
            bank_q[`IRQ_PEND_IDX][`IRQ_PEND_BIT] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         HOST_DATA_LINES_OE_O <= 1'b0;
         HOST_DATA_LINES_O <= '0;
      end else begin
         HOST_DATA_LINES_OE_O <= (state_d == PS_READ);
         HOST_DATA_LINES_O <= bank_q[rs];
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= irq_en & irq_pend;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         HOST_WR_STB_O <= 1'b0;
         HOST_WR_ADDR_O <= '0;
         HOST_WR_DATA_O <= '0;
         CORE_RD_DATA_O <= '0;
      end else begin
         HOST_WR_STB_O <= commit;
         HOST_WR_ADDR_O <= wr_addr_q;
         HOST_WR_DATA_O <= wr_data_q;
         CORE_RD_DATA_O <= bank_q[CORE_RD_ADDR_I];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);

   oe_on_read_a: assert property (
      (state_q == PS_IDLE && rd) |=> HOST_DATA_LINES_OE_O [*1] ##0
      (HOST_DATA_LINES_OE_O || !$past(rd)))
      else $error("data drivers not on during read");

   hiz_idle_a: assert property (
      HOST_DATA_LINES_OE_O |-> $past(rd))
      else $error("data drivers on outside a read cycle");

   deselect_hold_a: assert property (
      (state_q == PS_IDLE && !sel) |=> state_q == PS_IDLE)
      else $error("cycle started without chip select");

   write_store_a: assert property (
      (commit && wr_addr_q != `IRQ_PEND_IDX)
      |=> bank_q[$past(wr_addr_q)] == $past(wr_data_q))
      else $error("write byte not stored");

   trailing_edge_a: assert property (
      (state_q == PS_WRITE && wr) ##1 !wr |=> HOST_WR_STB_O)
      else $error("write not taken at strobe release");

   strobe_pulse_a: assert property (
      HOST_WR_STB_O |=> !HOST_WR_STB_O)
      else $error("write strobe longer than one cycle");

   irq_gate_a: assert property (
      IRQ_O |-> $past(irq_en) && $past(irq_pend))
      else $error("interrupt raised while disabled");

   irq_raise_a: assert property (
      (CORE_EVENT_I ##1 irq_en) |=> IRQ_O)
      else $error("enabled event did not raise interrupt");

   pend_set_a: assert property (
      CORE_EVENT_I |=> irq_pend)
      else $error("event lost against a clear");
endmodule : host_parallel_register_port

`default_nettype wire

// *** rtl/host_port_pkg.sv ***
// Types for the host parallel register port
`default_nettype none

package host_port_pkg;
   typedef logic [7:0] data_t;
   typedef logic [4:0] reg_idx_t;
   typedef enum logic [1:0] {
      PS_IDLE,
      PS_READ,
      PS_WRITE
   } port_state_t;
endpackage : host_port_pkg

`default_nettype wire

// *** rtl/host_port_regs.svh ***
// Constants for the host parallel register port
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// ----------------------------------------------------------------
// Register bank
// ----------------------------------------------------------------
`define BANK_DEPTH 32
`define BANK_RST_VAL 8'h00
`define IRQ_PEND_IDX 5'h1E
`define IRQ_PEND_BIT 0
`define IRQ_CTRL_IDX 5'h1F
`define IRQ_EN_BIT 0

// ----------------------------------------------------------------
// Synchroniser bus layout
// ----------------------------------------------------------------
`define SYNC_WIDTH 16
`define SYNC_RST_VAL 16'hE000
`define SYNC_CS_BIT 15
`define SYNC_RD_BIT 14
`define SYNC_WR_BIT 13
`define SYNC_RS_MSB 12
`define SYNC_RS_LSB 8
`define SYNC_DAT_MSB 7
`define SYNC_DAT_LSB 0

`endif

// *** rtl/pin_sync.sv ***
// Two-flop synchroniser for a group of pins
`default_nettype none

module pin_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // First stage is read only by the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : pin_sync

`default_nettype wire

// *** tb/host_bus_model.sv ***
// Host bus model for the parallel register port
`default_nettype none
module host_bus_model (
   input wire logic clk_i,
   input wire logic [7:0] dev_d_i,
   input wire logic dev_oe_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic [4:0] rs_o,
   output logic [7:0] bus_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv = 1'b0;
   logic [7:0] hd = 8'h00;
   logic [7:0] last = 8'h00;
   // Released bus toggles, so a stale byte never reads as valid
   assign bus_o = dev_oe_i ? dev_d_i : (drv ? hd : ~last);
   always @(posedge clk_i) last <= bus_o;
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      rs_o = 5'h00;
   end
   // One bus cycle; a stands for the host's low address lines
   task automatic cyc(input logic wr, input logic cs, input logic [4:0] a,
      input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge clk_i);
      rs_o <= a;
      hd <= d;
      drv <= wr;
      cs_n_o <= ~cs;
      rd_n_o <= wr;
      wr_n_o <= ~wr;
      repeat (4) @(posedge clk_i);
      for (n = 0; n < 6 && !wr && cs && dev_oe_i !== 1'b1; n++)
         @(posedge clk_i);
      q = dev_oe_i ? dev_d_i : 8'hXX;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      // Hold select, address and data past release
      repeat (3) @(posedge clk_i);
      cs_n_o <= 1'b1;
      drv <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : cyc
endmodule : host_bus_model
`default_nettype wire

// *** tb/tb_host_parallel_register_port.sv ***
// Self-checking bench for the host parallel register port
`default_nettype none
module tb_host_parallel_register_port;
   timeunit 1ns;
   timeprecision 1ns;
   import host_port_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cs_n, rd_n, wr_n, oe, irq, hstb;
   logic ev = 1'b0;
   logic cwe = 1'b0;
   logic [4:0] rs;
   reg_idx_t cwa = 5'h00;
   reg_idx_t cra = 5'h00;
   reg_idx_t hwa, sa;
   data_t cwd = 8'h00;
   data_t bus, dout, crd, hwd, sd;
   data_t mem [32] = '{default: 8'h00};
   logic [31:0] seed = 32'hED67;
   int fail_count = 0;
   int n_compared = 0;
   int n_stb = 0;
   host_bus_model u_host_bus_model (.clk_i(clk), .dev_d_i(dout),
      .dev_oe_i(oe), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .rs_o(rs), .bus_o(bus));
   host_parallel_register_port u_host_parallel_register_port (
      .MCLK_I(clk), .RST_N_I(rst_n), .REGISTER_SELECT_LINES_I(rs),
      .CHIP_SEL_N_I(cs_n), .READ_N_I(rd_n), .WRITE_N_I(wr_n),
      .HOST_DATA_LINES_I(bus), .HOST_DATA_LINES_O(dout),
      .HOST_DATA_LINES_OE_O(oe), .IRQ_O(irq), .CORE_EVENT_I(ev),
      .CORE_WR_EN_I(cwe), .CORE_WR_ADDR_I(cwa), .CORE_WR_DATA_I(cwd),
      .CORE_RD_ADDR_I(cra), .CORE_RD_DATA_O(crd), .HOST_WR_STB_O(hstb),
      .HOST_WR_ADDR_O(hwa), .HOST_WR_DATA_O(hwd));
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (hstb === 1'b1) begin
      n_stb++;
      sa = hwa;
      sd = hwd;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic exp_irq();
      return mem[31][0] & mem[30][0];
   endfunction : exp_irq
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // Hang guard, far beyond the fewer than a thousand cycles the run needs
   initial begin
      #400us;
      fail_count++;
      end_of_test();
   end
   // --------
   // Tests
   // --------
   initial begin
      data_t q;
      reg_idx_t a;
      int w;
      w = 0;
      repeat (8) @(posedge clk);
      chk(8'({oe, irq, hstb}), 8'h00);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(8'({oe, irq, hstb}), 8'h00);
      for (int i = 0; i < 26; i++) begin
         seed = xs(seed);
         a = (i < 2) ? 5'(i * 31) : seed[12:8];
         if (a == 5'h1E) a = 5'h1D;
         u_host_bus_model.cyc(1'b1, i != 9, a, seed[7:0], q);
         if (i != 9) begin
            mem[a] = seed[7:0];
            w++;
            chk({3'h0, sa}, {3'h0, a});
            chk(sd, seed[7:0]);
         end
         chk(8'(n_stb), 8'(w));
      end
      chk(8'(irq), 8'(exp_irq()));
      $display("test random writes done");
      @(posedge clk);
      cwa <= 5'h0A;
      cwd <= seed[23:16];
      cwe <= 1'b1;
      @(posedge clk);
      cwe <= 1'b0;
      mem[10] = seed[23:16];
      for (int i = 0; i < 32; i++) begin
         cra <= 5'(i);
         u_host_bus_model.cyc(1'b0, 1'b1, 5'(i), 8'h00, q);
         chk(q, mem[i]);
         chk(crd, mem[i]);
      end
      chk(8'(oe), 8'h00);
      // A read strobe without chip select must leave the bus undriven
      u_host_bus_model.cyc(1'b0, 1'b0, 5'h1F, 8'h00, q);
      chk(q, 8'hXX);
      $display("test readback done");
      for (int e = 0; e < 2; e++) begin
         u_host_bus_model.cyc(1'b1, 1'b1, 5'h1F, 8'(e), q);
         mem[31] = 8'(e);
         @(posedge clk);
         ev <= 1'b1;
         @(posedge clk);
         ev <= 1'b0;
         mem[30][0] = 1'b1;
         repeat (3) @(posedge clk);
         chk(8'(irq), 8'(exp_irq()));
         u_host_bus_model.cyc(1'b1, 1'b1, 5'h1E, 8'h00, q);
         mem[30] = 8'h00;
         chk(8'(irq), 8'(exp_irq()));
      end
      $display("test interrupt done");
      end_of_test();
   end
endmodule : tb_host_parallel_register_port
`default_nettype wire
